/* File: tb_tcir_claim_ident.sv */
// bench for the claim and identity register bank
module tb_tcir_claim_ident;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_b = 0, sEn = 1, nEn = 0, ce = 1, wbAck, wbAck2;
   logic [31:0] wbDatO, wbDatO2;
   logic [3:0] claimTag;
   tcir_pkg::tcir_wb_req_s wbReq = '0;
   int n_fail = 0, samples_checked = 0;
   // write flag, address, write data or expected read data
   logic [40:0] tab [14] = '{
      {1'b1,8'h00,32'h5},{1'b0,8'h04,32'h5},{1'b1,8'h00,32'h8},
      {1'b0,8'h04,32'hD},{1'b1,8'h04,32'h5},{1'b0,8'h04,32'h8},
      {1'b0,8'h00,32'hF},{1'b1,8'h0C,32'h0},{1'b0,8'h0C,32'h350001},
      {1'b0,8'h14,32'h13},{1'b1,8'h10,32'hFF},{1'b0,8'h10,32'h0},
      {1'b0,8'h08,32'hC8},{1'b0,8'h20,32'h0}};
   tcir_claim_ident i_tcir_claim_ident (.clk, .rst_b, .clkEn(ce), .wbReq,
      .wbDatO, .wbAck, .secureNoninvasiveEn(sEn),
      .nonsecureNoninvasiveEn(nEn), .claimTag);
   // second bank built without the security extension, same bus
   tcir_claim_ident #(.HAS_SECURITY(1'b0)) i_tcir_claim_ident_nosec (
      .clk, .rst_b, .clkEn(ce), .wbReq, .wbDatO(wbDatO2), .wbAck(wbAck2),
      .secureNoninvasiveEn(sEn), .nonsecureNoninvasiveEn(nEn),
      .claimTag());
   // 100 MHz clock
   initial forever #5 clk = ~clk;
   // one classic cycle; bounded wait, a read compares the row's data
   task automatic bus(input logic [40:0] r);
      int n = 0;
      wbReq <= {2'h3, r[40], 4'hF, r[39:0]};
      do @(posedge clk); while (wbAck !== 1'b1 && ++n < 20);
      wbReq <= '0;
      samples_checked++;
      if (wbAck !== 1'b1) begin
         n_fail++;
         $display("Error ack exp 1 got %b", wbAck);
      end
      if (!r[40] && r[39:32] == 8'h08 && wbDatO2 !== {26'h0, r[5:0]}) begin
         n_fail++;
         $display("Error nosec status exp %h got %h", r[5:0], wbDatO2);
      end
      if (!r[40]) begin
         samples_checked++;
         if (wbAck !== 1'b1 || wbDatO !== r[31:0]) begin
            n_fail++;
            $display("Error read %h exp %h got %h", r[39:32], r[31:0], wbDatO);
         end
      end
      @(posedge clk);
   endtask : bus
   // reset, table walk, then level change and reset in mid-run
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      foreach (tab[i]) bus(tab[i]);
      sEn <= 0;
      nEn <= 1;
      repeat (4) @(posedge clk);
      bus({1'b0, 8'h08, 32'h8C});
      rst_b <= 0;
      @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      bus({1'b0, 8'h04, 32'h0});
      // frozen by clock enable: request must not be taken
      ce <= 0;
      wbReq <= {2'h3, 1'b1, 4'hF, 8'h00, 32'hF};
      repeat (3) @(posedge clk);
      samples_checked++;
      if (wbAck !== 1'b0 || claimTag !== 4'h0) begin
         n_fail++;
         $display("Error frozen tag exp 0 got %h", claimTag);
      end
      ce <= 1;
      do @(posedge clk); while (wbAck !== 1'b1);
      wbReq <= '0;
      @(posedge clk);
      samples_checked++;
      if (claimTag !== 4'hF) begin
         n_fail++;
         $display("Error claim tag exp F got %h", claimTag);
      end
      end_of_test();
   end
   // hang guard, far beyond the fewer than a hundred cycles needed
   initial begin
      #20000;
      n_fail++;
      end_of_test();
   end
   task automatic end_of_test;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
endmodule : tb_tcir_claim_ident

/* File: tcir_claim_ident.sv */
// claim tag and identity register bank behind a classic wishbone slave
//
// Function
// - claim set reads ones on four low bits
// - writing one to claim set sets tag bit
// - claim clear reads present claim tag value
// - writing one to claim clear clears bit
// - bits 7:6 report secure non-invasive level
// - no security extension forces that field zero
// - secure invasive field reads 00
// - non-secure non-invasive reads 10 or 11
// - non-secure invasive field reads 00
// - architect code and architecture id constant
// - architecture bit 20 always reads one
// - architecture revision field reads 0x5
// - identity registers ignore writes
// - component subtype reads 0001
// - main type reads 0011, rest zero
// - reserved device ident reads zero
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`include "tcir_regs.svh"

module tcir_claim_ident #(
   parameter logic [10:0] ARCHITECT_CODE  = 11'h001, // arbitrary value
   parameter logic [15:0] ARCH_IDENTIFIER = 16'h0001, // arbitrary value
   parameter bit          HAS_SECURITY    = 1'b1
) (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic                  clkEn,
   input  wire tcir_pkg::tcir_wb_req_s wbReq,
   output logic [31:0]                wbDatO,
   output logic                       wbAck,
   input  wire logic                  secureNoninvasiveEn,
   input  wire logic                  nonsecureNoninvasiveEn,
   output logic [`TCIR_CLAIM_BITS-1:0] claimTag
);

   // elaboration check: the claim width is fixed by the decode below
   if (`TCIR_CLAIM_BITS != 4) begin : gBadClaim
      $error("claim tag width must be four");
   end

   logic [1:0] secNidSync;
   logic [1:0] nsNidSync;
   logic       secNidLvl;
   logic       nsNidLvl;
   logic       access;
   logic       wrStrobe;
   logic [3:0] next_claimTag;
   logic [31:0] next_rdData;
   tcir_pkg::tcir_perm_s permWord;
   tcir_pkg::tcir_arch_s archWord;

   // enables arrive from the authentication logic, another domain
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         secNidSync <= 2'h0;
         nsNidSync  <= 2'h0;
      end else if (clkEn) begin
         secNidSync <= {secNidSync[0], secureNoninvasiveEn};
         nsNidSync  <= {nsNidSync[0], nonsecureNoninvasiveEn};
      end
   end

   assign secNidLvl = secNidSync[1];
   assign nsNidLvl  = nsNidSync[1];

   // a request is served once; ack low gives the single answer cycle
   assign access   = wbReq.cyc & wbReq.stb & ~wbAck;
   assign wrStrobe = access & wbReq.we & wbReq.sel[0];

   // claim tag update; only byte lane 0 carries claim bits
   always_comb begin
      next_claimTag = claimTag;
      if (wrStrobe && wbReq.adr == `TCIR_OFF_CLAIM_SET) begin
         next_claimTag = claimTag | wbReq.dat[3:0];
      end else if (wrStrobe && wbReq.adr == `TCIR_OFF_CLAIM_CLR) begin
         next_claimTag = claimTag & ~wbReq.dat[3:0];
      end
   end

   // claim tag register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         claimTag <= `TCIR_CLAIM_RESET;
      end else if (clkEn) begin
         claimTag <= next_claimTag;
      end
   end

   // permission status fields
   always_comb begin
      permWord.secureNoninvasiveLevel = `TCIR_LVL_NONE;
      if (HAS_SECURITY) begin
         permWord.secureNoninvasiveLevel = secNidLvl ?
            `TCIR_LVL_ENABLED : `TCIR_LVL_DISABLED;
      end
      permWord.secureInvasiveLevel = `TCIR_LVL_NONE;
      permWord.nonsecureNoninvasiveLevel = nsNidLvl ?
         `TCIR_LVL_ENABLED : `TCIR_LVL_DISABLED;
      permWord.nonsecureInvasiveLevel = `TCIR_LVL_NONE;
   end

   // architecture word is pure constant, so writes cannot touch it
   always_comb begin
      archWord.architect      = ARCHITECT_CODE;
      archWord.present        = `TCIR_ARCH_PRESENT;
      archWord.revision       = `TCIR_ARCH_REVISION;
      archWord.archIdentifier = ARCH_IDENTIFIER;
   end

   // read decode; unmapped offsets read zero and still ack
   always_comb begin
      next_rdData = 32'h0000_0000;
      case (wbReq.adr)
         `TCIR_OFF_CLAIM_SET: begin
            next_rdData[3:0] = `TCIR_CLAIM_IMPL;
         end
         `TCIR_OFF_CLAIM_CLR: begin
            next_rdData[3:0] = claimTag;
         end
         `TCIR_OFF_PERM_STAT: begin
            next_rdData[7:0] = permWord;
         end
         `TCIR_OFF_ARCH_IDENT: begin
            next_rdData = archWord;
         end
         `TCIR_OFF_DEV_RSVD: begin
            next_rdData = 32'h0000_0000;
         end
         `TCIR_OFF_COMP_TYPE: begin
            next_rdData[7:0] = {`TCIR_TYPE_SUB, `TCIR_TYPE_MAJOR};
         end
         default: begin
            next_rdData = 32'h0000_0000;
         end
      endcase
   end

   // answer one cycle after the request, dropped the next cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wbAck  <= 1'b0;
         wbDatO <= 32'h0000_0000;
      end else if (clkEn) begin
         wbAck  <= access;
         wbDatO <= (access && !wbReq.we) ? next_rdData : 32'h0000_0000;
      end
   end

endmodule : tcir_claim_ident

/* File: tcir_claim_ident_asserts.sv */
// checker for the claim and identity register bank
module tcir_claim_ident_asserts (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire tcir_pkg::tcir_wb_req_s wbReq,
   input wire logic [31:0] wbDatO,
   input wire logic wbAck,
   input wire logic [3:0] claimTag
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // master still holds its request in the ack cycle
   wire [7:0] a = wbReq.adr;
   wire [3:0] d = wbReq.dat[3:0];
   wire [31:0] q = wbDatO;
   wire rd = wbAck & ~wbReq.we;
   wire wr = clkEn & wbReq.cyc & wbReq.stb & wbReq.we & ~wbAck;
   wire ws = wr & wbReq.sel[0] & (a == 8'h00);
   wire wc = wr & wbReq.sel[0] & (a == 8'h04);
   AST_SET_RD: assert property (rd && a == 8'h00 |-> q == 32'hF)
      else $error("set read");
   AST_SET_WR: assert property (ws |=> claimTag == $past(claimTag | d))
      else $error("set write");
   AST_CLR_WR: assert property (wc |=> claimTag == $past(claimTag & ~d))
      else $error("clear write");
   AST_CLR_RD:
      assert property (rd && a == 8'h04 |-> q == {28'h0, claimTag})
      else $error("clear read");
   AST_PERM:
      assert property (rd && a == 8'h08 |-> q[3] && {q[5:4], q[1:0]} == 4'h0)
      else $error("status read");
   AST_ARCH:
      assert property (rd && a == 8'h0C |-> q[20:16] == 5'h15)
      else $error("arch read");
   AST_TYPE: assert property (rd && a == 8'h14 |-> q == 32'h13)
      else $error("type read");
   AST_RSVD: assert property (rd && a == 8'h10 |-> q == 32'h0)
      else $error("reserved read");
   // main paths reached
   cover property (ws);
   cover property (wc);
   cover property (rd && a == 8'h0C);
endmodule : tcir_claim_ident_asserts
bind tcir_claim_ident tcir_claim_ident_asserts i_chk (
   .clk, .rst_b, .clkEn, .wbReq, .wbDatO, .wbAck, .claimTag);

/* File: tcir_pkg.sv */
// types shared by the claim and identity register bank
package tcir_pkg;

   // fields of the debug permission status word, low byte
   typedef struct packed {
      logic [1:0] secureNoninvasiveLevel;
      logic [1:0] secureInvasiveLevel;
      logic [1:0] nonsecureNoninvasiveLevel;
      logic [1:0] nonsecureInvasiveLevel;
   } tcir_perm_s;

   // fields of the architecture identification word
   typedef struct packed {
      logic [10:0] architect;
      logic        present;
      logic [3:0]  revision;
      logic [15:0] archIdentifier;
   } tcir_arch_s;

   // classic wishbone request from the master
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } tcir_wb_req_s;

endpackage : tcir_pkg

/* File: tcir_regs.svh */
// register offsets, field positions and constant values of the claim/identity bank
`ifndef TCIR_REGS_SVH
`define TCIR_REGS_SVH

// byte offsets within the bank (word aligned)
`define TCIR_OFF_CLAIM_SET   8'h00
`define TCIR_OFF_CLAIM_CLR   8'h04
`define TCIR_OFF_PERM_STAT   8'h08
`define TCIR_OFF_ARCH_IDENT  8'h0C
`define TCIR_OFF_DEV_RSVD    8'h10
`define TCIR_OFF_COMP_TYPE   8'h14

// claim tag
`define TCIR_CLAIM_BITS      4
`define TCIR_CLAIM_RESET     4'h0
`define TCIR_CLAIM_IMPL      4'hF

// permission status field codes
`define TCIR_LVL_NONE        2'h0
`define TCIR_LVL_DISABLED    2'h2
`define TCIR_LVL_ENABLED     2'h3

// architecture identification fields
`define TCIR_ARCH_PRESENT    1'h1
`define TCIR_ARCH_REVISION   4'h5

// component type fields
`define TCIR_TYPE_SUB        4'h1
`define TCIR_TYPE_MAJOR      4'h3

`endif
